// [ccsr_cfg.svh]
/*
 * Constants of the clock conditioner shadow register bank: offsets,
 * field positions, fixed patterns, reset values and timing counts.
 * Assumes it is included by bare name from the package and modules.
 */
`ifndef CCSR_CFG_SVH
`define CCSR_CFG_SVH

`define CCSR_ADDR_W 16
`define CCSR_DATA_W 32
`define CCSR_OFS_STATUS 16'h8110
`define CCSR_OFS_R0 16'h8114
`define CCSR_OFS_R11 16'h8124
`define CCSR_OFS_R13 16'h8128
`define CCSR_RD_UNMAPPED 32'h00000000

`define CCSR_BUSY_BIT 0
`define CCSR_TAG_MSB 3
`define CCSR_TAG_LSB 0
`define CCSR_TAG_R0 4'h0
`define CCSR_TAG_R11 4'hB
`define CCSR_TAG_R13 4'hD

`define CCSR_R0_DLY_MSB 7
`define CCSR_R0_DLY_LSB 4
`define CCSR_R0_DIV_MSB 15
`define CCSR_R0_DIV_LSB 8
`define CCSR_R0_EN_BIT 16
`define CCSR_R0_MUX_MSB 18
`define CCSR_R0_MUX_LSB 17
`define CCSR_R0_UNUSED_W 12
`define CCSR_R0_RST_BIT 31
`define CCSR_R0_DLY_RST 4'h0
`define CCSR_R0_DIV_RST 8'h01
`define CCSR_R0_DIV_ILLEGAL 8'h00
`define CCSR_R0_MUX_BYPASS 2'h0
`define CCSR_R0_MUX_DIVIDED 2'h1
`define CCSR_R0_MUX_DELAYED 2'h2
`define CCSR_R0_MUX_DIV_DLY 2'h3

`define CCSR_R11_LOW_UNUSED_W 11
`define CCSR_R11_PHASE_DETECTOR_HIGH_FREQ_FLAG_BIT 15
`define CCSR_R11_FIXED_HI 16'h0082

`define CCSR_R13_FILT_MSB 13
`define CCSR_R13_FILT_LSB 4
`define CCSR_R13_FILT_RST 10'h000
`define CCSR_R13_FREQ_MSB 21
`define CCSR_R13_FREQ_LSB 14
`define CCSR_R13_FREQ_RST 8'h00
`define CCSR_R13_FIXED_HI 10'h00A

`define CCSR_CLK_PERIOD_NS 25
`define CCSR_CHIP_RST_NS 10000
`define CCSR_CHIP_RST_CYC \
    ((`CCSR_CHIP_RST_NS + `CCSR_CLK_PERIOD_NS - 1) / `CCSR_CLK_PERIOD_NS)
`define CCSR_WAIT_W 9
`define CCSR_BITCNT_W 5
`define CCSR_LAST_BIT 5'h1F

`endif

// [ccsr_chip_model.sv]
/*
 * Behavioural model of the external clock conditioner's serial port.
 * Assumes serClk idles low, data is taken on its rising edge and a
 * latch pulse closes each word.
 */
`timescale 1ns/1ps
`include "ccsr_cfg.svh"

module ccsr_chip_model
    import ccsr_pkg::*;
(
    input wire logic serClk,
    input wire logic serData,
    input wire logic serLatch,
    output ccsr_pkg::ccsr_word_t rxWord,
    output logic [5:0] rxBits,
    output logic [7:0] rxCount
);
    import ccsr_pkg::*;
    ccsr_word_t shift_q = '0;
    logic [5:0] bitTot_q = '0;
    logic [5:0] mark_q = '0;
    ccsr_word_t image [16];
    initial begin
        rxWord = '0;
        rxBits = '0;
        rxCount = '0;
    end
    always @(posedge serClk) begin
        shift_q <= {shift_q[30:0], serData};
        bitTot_q <= bitTot_q + 6'h01;
    end
    always @(posedge serLatch) begin
        rxWord <= shift_q;
        rxBits <= bitTot_q - mark_q;
        mark_q <= bitTot_q;
        rxCount <= rxCount + 8'h01;
        if (shift_q[3:0] == 4'h0 && shift_q[31]) begin
            for (int i = 0; i < 16; i++) begin
                image[i] <= '0;
            end
        end else begin
            image[shift_q[3:0]] <= shift_q;
        end
    end
endmodule

// [ccsr_pkg.sv]
/*
 * Types shared by the clock conditioner shadow register bank.
 * Assumes ccsr_cfg.svh is on the include path.
 */
`include "ccsr_cfg.svh"

package ccsr_pkg;
    typedef logic [`CCSR_ADDR_W-1:0] ccsr_addr_t;
    typedef logic [`CCSR_DATA_W-1:0] ccsr_word_t;
    typedef enum logic [1:0] {SER_IDLE, SER_LOW, SER_HIGH, SER_LATCH}
        ccsr_ser_state_t;
    typedef enum logic [1:0] {CTL_IDLE, CTL_SEND, CTL_RSTWAIT}
        ccsr_ctl_state_t;
endpackage

// [ccsr_serial_tx.sv]
/*
 * Serial word shifter toward the external clock conditioner: 32 bits,
 * most significant first, data changes on the falling serial clock and
 * is taken by the chip on the rising one; a latch pulse follows the word.
 * Assumes start is a one-cycle pulse, given only while idle.
 */
`timescale 1ns/1ps
`include "ccsr_cfg.svh"

module ccsr_serial_tx
    import ccsr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic start,
    input wire ccsr_pkg::ccsr_word_t word,
    output logic done,
    output logic serClk,
    output logic serData,
    output logic serLatch
);
    ccsr_ser_state_t state_q;
    ccsr_word_t shift_q;
    logic [`CCSR_BITCNT_W-1:0] bitCnt_q;
    wire lastBit = (bitCnt_q == `CCSR_LAST_BIT);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= SER_IDLE;
            shift_q <= '0;
            bitCnt_q <= '0;
            serClk <= 1'b0;
            serData <= 1'b0;
            serLatch <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_q)
                SER_IDLE: begin
                    serLatch <= 1'b0;
                    if (start) begin
                        shift_q <= word;
                        bitCnt_q <= '0;
                        state_q <= SER_LOW;
                    end
                end
                SER_LOW: begin
                    serClk <= 1'b0;
                    serData <= shift_q[`CCSR_DATA_W-1];
                    state_q <= SER_HIGH;
                end
                SER_HIGH: begin
                    serClk <= 1'b1;
                    shift_q <= {shift_q[`CCSR_DATA_W-2:0], 1'b0};
                    bitCnt_q <= bitCnt_q + 1'b1;
                    state_q <= lastBit ? SER_LATCH : SER_LOW;
                end
                SER_LATCH: begin
                    serClk <= 1'b0;
                    serLatch <= 1'b1;
                    done <= 1'b1;
                    state_q <= SER_IDLE;
                end
                default: state_q <= SER_IDLE;
            endcase
        end
    end
endmodule

// [ccsr_shadow_regs.sv]
/*
 * Shadow register bank of an external clock conditioner: channel-0
 * output register, PLL input-divider register, VCO filter / input
 * frequency register and a status register with the busy bit.
 * Assumes a plain register port (read data one cycle after the read
 * strobe), a power-up reset separate from the board reset, and that
 * software only makes full 32-bit accesses.
 */
`timescale 1ns/1ps
`include "ccsr_cfg.svh"

module ccsr_shadow_regs
    import ccsr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic powerOnRst,
    input wire ccsr_pkg::ccsr_addr_t addr,
    input wire ccsr_pkg::ccsr_word_t wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output ccsr_pkg::ccsr_word_t rdData,
    output logic ccBusy,
    output logic serClk,
    output logic serData,
    output logic serLatch
);
    import ccsr_pkg::*;

    // shadow fields; only the writable ones are stored
    logic [1:0] outputPathSelect_q;
    logic outputEnable_q;
    logic [7:0] outputDividerValue_q;
    logic [3:0] outputDelay_q;
    logic phaseDetectorHighFreqFlag_q;
    logic [9:0] vcoFilter_q;
    logic [7:0] inputFreqMhz_q;

    ccsr_ctl_state_t ctlState_q;
    ccsr_ctl_state_t ctlState_d;
    logic [`CCSR_WAIT_W-1:0] waitCnt_q;
    logic chipRstPending_q;
    logic txStart_q;
    ccsr_word_t txWord_q;
    logic txDone;

    // address decode: whole byte addresses, since only full words ever
    // reach the bank
    wire hitStatus = (addr == `CCSR_OFS_STATUS);
    wire hitR0 = (addr == `CCSR_OFS_R0);
    wire hitR11 = (addr == `CCSR_OFS_R11);
    wire hitR13 = (addr == `CCSR_OFS_R13);
    wire hitShadow = hitR0 | hitR11 | hitR13;

    // a write during a transfer is dropped so the chip never sees a
    // half-shifted word overwritten
    wire ctlIdle = (ctlState_q == CTL_IDLE);
    wire wrAccept = wrStrobe & hitShadow & ctlIdle;
    wire wrR0 = wrAccept & hitR0;
    wire wrR11 = wrAccept & hitR11;
    wire wrR13 = wrAccept & hitR13;
    wire chipRstReq = wrR0 & wrData[`CCSR_R0_RST_BIT];

    // divider value zero is illegal; it is forced to the reset value
    wire [7:0] wrDivField = wrData[`CCSR_R0_DIV_MSB:`CCSR_R0_DIV_LSB];
    wire divIllegal = (wrDivField == `CCSR_R0_DIV_ILLEGAL);
    wire [7:0] wrDivLegal = divIllegal ? `CCSR_R0_DIV_RST : wrDivField;

    // fields of the written word, named once for the store and send paths
    wire [1:0] wrMux = wrData[`CCSR_R0_MUX_MSB:`CCSR_R0_MUX_LSB];
    wire wrEn = wrData[`CCSR_R0_EN_BIT];
    wire [3:0] wrDly = wrData[`CCSR_R0_DLY_MSB:`CCSR_R0_DLY_LSB];
    wire wrRstBit = wrData[`CCSR_R0_RST_BIT];
    wire wrDiv4 = wrData[`CCSR_R11_PHASE_DETECTOR_HIGH_FREQ_FLAG_BIT];
    wire [9:0] wrFilt = wrData[`CCSR_R13_FILT_MSB:`CCSR_R13_FILT_LSB];
    wire [7:0] wrFreq = wrData[`CCSR_R13_FREQ_MSB:`CCSR_R13_FREQ_LSB];

    // readable images, fixed bits forced so reads show the chip's layout
    wire [`CCSR_DATA_W-1:0] imgR0 = {
        chipRstPending_q,
        {`CCSR_R0_UNUSED_W{1'b0}},
        outputPathSelect_q,
        outputEnable_q,
        outputDividerValue_q,
        outputDelay_q,
        `CCSR_TAG_R0
    };
    wire [`CCSR_DATA_W-1:0] imgR11 = {
        `CCSR_R11_FIXED_HI,
        phaseDetectorHighFreqFlag_q,
        {`CCSR_R11_LOW_UNUSED_W{1'b0}},
        `CCSR_TAG_R11
    };
    wire [`CCSR_DATA_W-1:0] imgR13 = {
        `CCSR_R13_FIXED_HI,
        inputFreqMhz_q,
        vcoFilter_q,
        `CCSR_TAG_R13
    };
    wire [`CCSR_DATA_W-1:0] imgStatus = {
        {(`CCSR_DATA_W-1){1'b0}},
        ccBusy
    };

    // word sent to the chip: the written value in the chip's layout
    wire [`CCSR_DATA_W-1:0] sendR0 = {
        wrRstBit,
        {`CCSR_R0_UNUSED_W{1'b0}},
        wrMux,
        wrEn,
        wrDivLegal,
        wrDly,
        `CCSR_TAG_R0
    };
    wire [`CCSR_DATA_W-1:0] sendR11 = {
        `CCSR_R11_FIXED_HI,
        wrDiv4,
        {`CCSR_R11_LOW_UNUSED_W{1'b0}},
        `CCSR_TAG_R11
    };
    wire [`CCSR_DATA_W-1:0] sendR13 = {
        `CCSR_R13_FIXED_HI,
        wrFreq,
        wrFilt,
        `CCSR_TAG_R13
    };
    wire [`CCSR_DATA_W-1:0] sendWord =
        hitR0 ? sendR0 : (hitR11 ? sendR11 : sendR13);

    wire [`CCSR_DATA_W-1:0] rdMux =
        hitStatus ? imgStatus :
        hitR0 ? imgR0 :
        hitR11 ? imgR11 :
        hitR13 ? imgR13 : `CCSR_RD_UNMAPPED;

    localparam logic [`CCSR_WAIT_W-1:0] CHIP_RST_CYC =
        `CCSR_WAIT_W'(`CCSR_CHIP_RST_CYC);
    wire waitDone = (waitCnt_q == CHIP_RST_CYC);

    // the wait counts from the end of the reset word, so the chip has its
    // full reset time after it has taken the bit; a shorter wait is unsafe
    wire ctlRstWait = (ctlState_q == CTL_RSTWAIT);
    wire rstWaitEnd = ctlRstWait & waitDone;

    // busy already reads high in the accept cycle
    assign ccBusy = wrAccept | ~ctlIdle;

    always_comb begin
        ctlState_d = ctlState_q;
        case (ctlState_q)
            CTL_IDLE: begin
                if (wrAccept) begin
                    ctlState_d = CTL_SEND;
                end
            end
            CTL_SEND: begin
                if (txDone) begin
                    ctlState_d = chipRstPending_q ? CTL_RSTWAIT : CTL_IDLE;
                end
            end
            CTL_RSTWAIT: begin
                if (waitDone) begin
                    ctlState_d = CTL_IDLE;
                end
            end
            default: ctlState_d = CTL_IDLE;
        endcase
    end

    // shadow fields: power-up reset only, the board reset leaves them
    always_ff @(posedge sys_clk or posedge powerOnRst) begin
        if (powerOnRst) begin
            outputPathSelect_q <= `CCSR_R0_MUX_BYPASS;
            outputEnable_q <= 1'b0;
            outputDividerValue_q <= `CCSR_R0_DIV_RST;
            outputDelay_q <= `CCSR_R0_DLY_RST;
        end else if (chipRstReq) begin
            outputPathSelect_q <= `CCSR_R0_MUX_BYPASS;
            outputEnable_q <= 1'b0;
            outputDividerValue_q <= `CCSR_R0_DIV_RST;
            outputDelay_q <= `CCSR_R0_DLY_RST;
        end else if (wrR0) begin
            outputPathSelect_q <= wrMux;
            outputEnable_q <= wrEn;
            outputDividerValue_q <= wrDivLegal;
            outputDelay_q <= wrDly;
        end
    end

    always_ff @(posedge sys_clk or posedge powerOnRst) begin
        if (powerOnRst) begin
            phaseDetectorHighFreqFlag_q <= 1'b0;
        end else if (chipRstReq) begin
            phaseDetectorHighFreqFlag_q <= 1'b0;
        end else if (wrR11) begin
            phaseDetectorHighFreqFlag_q <= wrDiv4;
        end
    end

    always_ff @(posedge sys_clk or posedge powerOnRst) begin
        if (powerOnRst) begin
            vcoFilter_q <= `CCSR_R13_FILT_RST;
            inputFreqMhz_q <= `CCSR_R13_FREQ_RST;
        end else if (chipRstReq) begin
            vcoFilter_q <= `CCSR_R13_FILT_RST;
            inputFreqMhz_q <= `CCSR_R13_FREQ_RST;
        end else if (wrR13) begin
            vcoFilter_q <= wrFilt;
            inputFreqMhz_q <= wrFreq;
        end
    end

    // the self-clearing bit reads high until the chip reset time is over;
    // an idle control clears it too, since a board reset in mid wait
    // would otherwise leave it set and stretch the next write to any register
    always_ff @(posedge sys_clk or posedge powerOnRst) begin
        if (powerOnRst) begin
            chipRstPending_q <= 1'b0;
        end else if (chipRstReq) begin
            chipRstPending_q <= 1'b1;
        end else if (rstWaitEnd || ctlIdle) begin
            chipRstPending_q <= 1'b0;
        end
    end

    // transfer control follows the board reset; a board reset mid
    // transfer abandons the word, software must rewrite it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctlState_q <= CTL_IDLE;
        end else begin
            ctlState_q <= ctlState_d;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            waitCnt_q <= '0;
        end else if (ctlRstWait) begin
            waitCnt_q <= waitCnt_q + 1'b1;
        end else begin
            waitCnt_q <= '0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            txStart_q <= 1'b0;
            txWord_q <= '0;
        end else begin
            // word and start are registered so the shifter loads a word
            // that no longer depends on the bus
            txStart_q <= wrAccept;
            if (wrAccept) begin
                txWord_q <= sendWord;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdData <= '0;
        end else if (rdStrobe) begin
            rdData <= rdMux;
        end else begin
            // zero outside the read cycle, so a late sample shows no stale
            // value from an earlier access
            rdData <= '0;
        end
    end

    // the shifter follows the board reset like the control, so both
    // abandon a word together
    ccsr_serial_tx serTx (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(txStart_q),
        .word(txWord_q),
        .done(txDone),
        .serClk(serClk),
        .serData(serData),
        .serLatch(serLatch)
    );
endmodule

// [ccsr_shadow_regs_assertions.sv]
/*
 * Port checker of the shadow register bank.
 * Assumes one clock and that only full-word accesses are made.
 */
`timescale 1ns/1ps
`include "ccsr_cfg.svh"

module ccsr_shadow_regs_assertions
    import ccsr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic powerOnRst,
    input wire ccsr_pkg::ccsr_addr_t addr,
    input wire ccsr_pkg::ccsr_word_t wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire ccsr_pkg::ccsr_word_t rdData,
    input wire logic ccBusy,
    input wire logic serClk,
    input wire logic serData,
    input wire logic serLatch
);
    import ccsr_pkg::*;
    logic engIdle_q;
    wire shadowAddr;
    wire accept;
    wire chipRstReq;
    assign shadowAddr = addr == `CCSR_OFS_R0 || addr == `CCSR_OFS_R11
        || addr == `CCSR_OFS_R13;
    // writes landing while busy are dropped, so only idle ones count
    assign accept = wrStrobe && shadowAddr && engIdle_q;
    assign chipRstReq = accept && addr == `CCSR_OFS_R0 && wrData[31];
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            engIdle_q <= 1'b1;
        end else begin
            engIdle_q <= !ccBusy;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst || powerOnRst);
    sequence s_firstBit;
        ##3 !serClk ##1 serClk ##1 !serClk ##1 serClk;
    endsequence
    sequence s_wordDone;
        ##[60:70] serLatch;
    endsequence
    property p_sendStart;
        accept |-> s_firstBit;
    endproperty
    a_sendStart: assert property (p_sendStart)
        else $error("serial word did not start after write");
    property p_busyHold;
        accept |-> ccBusy throughout s_wordDone;
    endproperty
    a_busyHold: assert property (p_busyHold)
        else $error("busy dropped or latch missing in word");
    property p_busyOnWrite;
        wrStrobe && shadowAddr |-> ccBusy;
    endproperty
    a_busyOnWrite: assert property (p_busyOnWrite)
        else $error("busy low in write cycle");
    property p_linkIdle;
        !ccBusy |-> !serClk && !serLatch;
    endproperty
    a_linkIdle: assert property (p_linkIdle)
        else $error("link active while not busy");
    property p_statusRead;
        rdStrobe && addr == `CCSR_OFS_STATUS
            |=> rdData == {31'h0, $past(ccBusy)};
    endproperty
    a_statusRead: assert property (p_statusRead)
        else $error("status read disagrees with busy");
    property p_rdIdle;
        !$past(rdStrobe) |-> rdData == '0;
    endproperty
    a_rdIdle: assert property (p_rdIdle)
        else $error("read data outside its cycle");
    property p_pllFixed;
        rdStrobe && addr == `CCSR_OFS_R11 |=> rdData[3:0] == 4'hB
            && rdData[31:16] == 16'h0082 && rdData[14:4] == 11'h000;
    endproperty
    a_pllFixed: assert property (p_pllFixed)
        else $error("input divider fixed bits wrong");
    property p_vcoTag;
        rdStrobe && addr == `CCSR_OFS_R13
            |=> rdData[3:0] == 4'hD && rdData[31:22] == 10'h00A;
    endproperty
    a_vcoTag: assert property (p_vcoTag)
        else $error("vco register fixed bits wrong");
    property p_outFields;
        rdStrobe && addr == `CCSR_OFS_R0 |=> rdData[3:0] == 4'h0
            && rdData[30:19] == 12'h000 && rdData[15:8] != 8'h00;
    endproperty
    a_outFields: assert property (p_outFields)
        else $error("output register fields wrong");
    property p_chipRstHold;
        chipRstReq |-> ##[467:467] ccBusy;
    endproperty
    a_chipRstHold: assert property (p_chipRstHold)
        else $error("conditioner reset wait too short");
endmodule

bind ccsr_shadow_regs ccsr_shadow_regs_assertions u_chk (.sys_clk(sys_clk),
    .rst(rst), .powerOnRst(powerOnRst), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .ccBusy(ccBusy), .serClk(serClk), .serData(serData),
    .serLatch(serLatch));

// [tb_top.sv]
/*
 * Self-checking bench of the shadow register bank and its serial link.
 * Assumes the checker is bound and the chip model sits on the link.
 */
`timescale 1ns/1ps
`include "ccsr_cfg.svh"

module tb_top;
    import ccsr_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic powerOnRst = 1'b1;
    ccsr_addr_t addr = '0;
    ccsr_word_t wrData = '0;
    logic wrStrobe = 1'b0;
    logic rdStrobe = 1'b0;
    ccsr_word_t rdData;
    logic ccBusy;
    logic serClk;
    logic serData;
    logic serLatch;
    ccsr_word_t rxWord;
    logic [5:0] rxBits;
    logic [7:0] rxCount;
    logic [7:0] cnt0;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;
    always #12.5 sys_clk = ~sys_clk;
    ccsr_shadow_regs u_dut (.sys_clk(sys_clk), .rst(rst),
        .powerOnRst(powerOnRst), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
        .ccBusy(ccBusy), .serClk(serClk), .serData(serData),
        .serLatch(serLatch));
    ccsr_chip_model u_chip (.serClk(serClk), .serData(serData),
        .serLatch(serLatch), .rxWord(rxWord), .rxBits(rxBits),
        .rxCount(rxCount));
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input ccsr_word_t got, input ccsr_word_t exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h not %h", $time, got, exp);
        end
    endtask
    task automatic wr(input ccsr_addr_t a, input ccsr_word_t d);
        @(posedge sys_clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge sys_clk);
        wrStrobe <= 1'b0;
    endtask
    task automatic rc(input ccsr_addr_t a, input ccsr_word_t exp);
        @(posedge sys_clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge sys_clk);
        rdStrobe <= 1'b0;
        #1;
        chk(rdData, exp);
    endtask
    task automatic waitIdle();
        int n;
        n = 0;
        #1;
        while (ccBusy !== 1'b0 && n < 1000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk({31'h0, ccBusy}, 32'h0);
    endtask
    // write, wait for the link, then compare the received word and readback
    task automatic prog(input ccsr_addr_t a, input ccsr_word_t d,
                        input ccsr_word_t exp);
        wr(a, d);
        waitIdle();
        chk(rxWord, exp);
        chk({26'h0, rxBits}, 32'h00000020);
        rc(a, exp);
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            results();
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        powerOnRst <= 1'b0;
        rc(`CCSR_OFS_R0, 32'h00000100);
        rc(`CCSR_OFS_R11, 32'h0082000B);
        rc(`CCSR_OFS_R13, 32'h0280000D);
        rc(`CCSR_OFS_STATUS, 32'h00000000);
        rc(16'h8000, 32'h00000000);
        $display("defaults test done");
        for (int m = 0; m < 4; m++) begin
            prog(`CCSR_OFS_R0, 32'h0001053F | (ccsr_word_t'(m) << 17),
                 32'h00010530 | (ccsr_word_t'(m) << 17));
        end
        prog(`CCSR_OFS_R0, 32'h00000000, 32'h00000100);
        prog(`CCSR_OFS_R0, 32'h0000FF00, 32'h0000FF00);
        $display("output register test done");
        prog(`CCSR_OFS_R11, 32'hFFFFFFFF, 32'h0082800B);
        prog(`CCSR_OFS_R11, 32'h00000000, 32'h0082000B);
        prog(`CCSR_OFS_R13, 32'h0019005F, 32'h0299005D);
        $display("pll register test done");
        cnt0 = rxCount;
        wr(`CCSR_OFS_R13, 32'h0019005F);
        rc(`CCSR_OFS_STATUS, 32'h00000001);
        wr(`CCSR_OFS_R11, 32'hFFFFFFFF);
        waitIdle();
        rc(`CCSR_OFS_R11, 32'h0082000B);
        chk({24'h0, rxCount}, {24'h0, cnt0 + 8'h01});
        wr(`CCSR_OFS_STATUS, 32'hFFFFFFFF);
        rc(`CCSR_OFS_STATUS, 32'h00000000);
        $display("busy test done");
        prog(`CCSR_OFS_R11, 32'hFFFFFFFF, 32'h0082800B);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rc(`CCSR_OFS_R13, 32'h0299005D);
        rc(`CCSR_OFS_R0, 32'h0000FF00);
        rc(`CCSR_OFS_R11, 32'h0082800B);
        $display("board reset test done");
        wr(`CCSR_OFS_R0, 32'h80000530);
        rc(`CCSR_OFS_R0, 32'h80000100);
        repeat (300) @(posedge sys_clk);
        rc(`CCSR_OFS_STATUS, 32'h00000001);
        waitIdle();
        chk(rxWord, 32'h80000530);
        rc(`CCSR_OFS_R0, 32'h00000100);
        rc(`CCSR_OFS_R11, 32'h0082000B);
        rc(`CCSR_OFS_R13, 32'h0280000D);
        prog(`CCSR_OFS_R0, 32'h00020530, 32'h00020530);
        $display("conditioner reset test done");
        prog(`CCSR_OFS_R13, 32'h0019005F, 32'h0299005D);
        @(posedge sys_clk);
        powerOnRst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        powerOnRst <= 1'b0;
        rc(`CCSR_OFS_R13, 32'h0280000D);
        rc(`CCSR_OFS_R0, 32'h00000100);
        $display("power-up reset test done");
        results();
    end
endmodule
